// file: bench/eot_handler_model.sv
// Handler model: drives the connector inputs and watches the done and error lines
`timescale 1ns/10ps
module eot_handler_model
   import eot_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic done_in,
   input wire logic err_in,
   input wire logic [IN_W-1:0] pins_req_in,
   output logic [IN_W-1:0] ext_pins_out,
   output logic err_at_done_out,
   output logic [7:0] done_count_out
);
   logic done_q;
   initial
   begin
      done_q = 1'h0;
      ext_pins_out = 8'h00;
      err_at_done_out = 1'h0;
      done_count_out = 8'h00;
   end
   // A real handler reads the error line only when done rises
   always @(posedge clk_sys_in)
   begin
      done_q <= done_in;
      ext_pins_out <= pins_req_in;
      if (done_in && !done_q)
      begin
         err_at_done_out <= err_in;
         done_count_out <= done_count_out + 8'h01;
      end
   end
endmodule

// file: bench/tb_top.sv
// Self-checking testbench for the error output timing block
`timescale 1ns/10ps
module tb_top;
   import eot_pkg::*;
   localparam int unsigned CPM = 4;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic [AW-1:0] awaddr = 8'h00;
   logic [AW-1:0] araddr = 8'h00;
   logic [DW-1:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'h0;
   logic wvalid = 1'h0;
   logic bready = 1'h0;
   logic arvalid = 1'h0;
   logic rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rsp;
   logic [DW-1:0] rdata, rd_v;
   logic st = 1'h0;
   logic sa = 1'h0;
   logic dn = 1'h0;
   logic ce = 1'h0;
   logic re = 1'h0;
   logic [IN_W-1:0] pins_req = 8'ha5;
   logic [IN_W-1:0] pins;
   logic done_o, err_o, irq, seen_err;
   logic [7:0] seen_cnt;
   int n_mismatch = 0;
   int comparisons = 0;

   always #25 clk = ~clk;

   eot_err_output #(.CYC_PER_MS(CPM)) dut (.clk_sys_in(clk), .nrst_in(nrst),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .meas_start_in(st),
      .sampling_in(sa), .meas_done_in(dn), .contact_err_in(ce), .route_err_in(re),
      .ext_pins_in(pins), .measurement_done_output_out(done_o), .err_line_out(err_o),
      .irq_out(irq));

   eot_handler_model handler (.clk_sys_in(clk), .done_in(done_o), .err_in(err_o),
      .pins_req_in(pins_req), .ext_pins_out(pins), .err_at_done_out(seen_err),
      .done_count_out(seen_cnt));

   ////////////////////////////////////////////////////////////////////////////////
   task give_verdict;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task bit_is(input logic seen, input logic exp);
      check({31'h0, seen}, {31'h0, exp});
   endtask

   // Bus master: hold each channel until its own handshake, wait for the answer
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
      end
      while (bvalid !== 1'h1);
      rsp = bresp;
      bready <= 1'h0;
   endtask

   // Only the watchdog ends a wait for the answer
   task rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'h0;
      end
      while (rvalid !== 1'h1);
      rd_v = rdata;
      rsp = rresp;
      rready <= 1'h0;
   endtask

   // Measurement inputs as {start, sampling, done, contact, route}
   task step(input logic [4:0] v);
      @(posedge clk);
      {st, sa, dn, ce, re} <= v;
   endtask

   // One cycle of v, then idle; returns once the outputs have answered
   task evt(input logic [4:0] v);
      step(v);
      step(5'h00);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #(50 * 20000);
      n_mismatch++;
      give_verdict;
   end

   initial
   begin
      repeat (20) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      rd(ADDR_CTRL);
      check(rd_v, 32'h0);
      rd(ADDR_WIDTH);
      check(rd_v, 32'h5);
      rd(8'h20);
      check({30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(8'h20, 32'h1);
      check({30'h0, rsp}, {30'h0, RESP_SLVERR});
      // Asynchronous: contact errors show at once, with no done pulse
      evt(5'h02);
      bit_is(err_o, 1'h1);
      bit_is(done_o, 1'h0);
      check({24'h0, seen_cnt}, 32'h0);
      evt(5'h10);
      bit_is(err_o, 1'h0);
      evt(5'h12);
      bit_is(err_o, 1'h1);
      evt(5'h10);
      // Synchronous, 1 ms pulse
      wr(ADDR_CTRL, 32'h1);
      wr(ADDR_WIDTH, 32'h1);
      evt(5'h02);
      bit_is(err_o, 1'h0);
      // A done with no sampling error must not carry the earlier stray error
      evt(5'h04);
      bit_is(err_o, 1'h0);
      step(5'h09);
      evt(5'h08);
      bit_is(err_o, 1'h0);
      evt(5'h04);
      bit_is(err_o, 1'h1);
      bit_is(done_o, 1'h1);
      repeat (CPM - 1) @(posedge clk);
      #1;
      bit_is(done_o, 1'h1);
      @(posedge clk);
      #1;
      bit_is(done_o, 1'h0);
      bit_is(seen_err, 1'h1);
      evt(5'h10);
      bit_is(err_o, 1'h0);
      step(5'h0a);
      evt(5'h04);
      bit_is(err_o, 1'h1);
      evt(5'h10);
      // Width limits are clamped, not refused
      wr(ADDR_WIDTH, 32'h0);
      rd(ADDR_WIDTH);
      check(rd_v, 32'h1);
      wr(ADDR_WIDTH, 32'hc8);
      rd(ADDR_WIDTH);
      check(rd_v, 32'h64);
      // A write with lane 0 disabled leaves the width alone
      wstrb <= 4'h0;
      wr(ADDR_WIDTH, 32'h7);
      wstrb <= 4'hf;
      rd(ADDR_WIDTH);
      check(rd_v, 32'h64);
      // Level mode holds until the next start
      wr(ADDR_CTRL, 32'h3);
      evt(5'h04);
      repeat (30) @(posedge clk);
      #1;
      bit_is(done_o, 1'h1);
      evt(5'h10);
      bit_is(done_o, 1'h0);
      // Test mode
      rd(ADDR_IN);
      check(rd_v, 32'ha5);
      @(posedge clk);
      pins_req <= 8'h3c;
      repeat (4) @(posedge clk);
      rd(ADDR_IN);
      check(rd_v, 32'h3c);
      wr(ADDR_CTRL, 32'h4);
      wr(ADDR_FORCE, 32'h3);
      #1;
      bit_is(done_o, 1'h1);
      bit_is(err_o, 1'h1);
      rd(ADDR_OUT);
      check(rd_v, 32'h3);
      wr(ADDR_FORCE, 32'h1);
      evt(5'h02);
      bit_is(err_o, 1'h0);
      bit_is(done_o, 1'h1);
      wr(ADDR_CTRL, 32'h0);
      evt(5'h10);
      // Interrupt on contact error: raise, mask, clear
      wr(ADDR_CLR, 32'h7);
      wr(ADDR_EN, 32'h4);
      #1;
      bit_is(irq, 1'h0);
      evt(5'h02);
      bit_is(irq, 1'h1);
      rd(ADDR_STAT);
      check(rd_v, 32'h5);
      wr(ADDR_EN, 32'h0);
      #1;
      bit_is(irq, 1'h0);
      wr(ADDR_EN, 32'h4);
      wr(ADDR_CLR, 32'h4);
      #1;
      bit_is(irq, 1'h0);
      give_verdict;
   end
endmodule

// file: core/eot_err_output.sv
// Error line and measurement-done output timing with AXI4-Lite registers
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module eot_err_output
   import eot_pkg::*;
#(
   parameter int unsigned CYC_PER_MS = DONE_UNIT_CYC
)
(
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic [AW-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [DW-1:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [AW-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [DW-1:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic meas_start_in,
   input wire logic sampling_in,
   input wire logic meas_done_in,
   input wire logic contact_err_in,
   input wire logic route_err_in,
   input wire logic [IN_W-1:0] ext_pins_in,
   output logic measurement_done_output_out,
   output logic err_line_out,
   output logic irq_out
);

   typedef struct packed
   {
      logic aw_got;
      logic [AW-1:0] aw_addr;
      logic w_got;
      logic [DW-1:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [DW-1:0] rdata;
      logic [1:0] rresp;
      logic sync_mode;
      logic done_hold;
      logic test_mode;
      logic [MS_W-1:0] done_width;
      logic force_done;
      logic force_err;
      logic [EV_W-1:0] status;
      logic [EV_W-1:0] int_en;
      logic [IN_W-1:0] ext_s1;
      logic [IN_W-1:0] ext_s2;
      logic err_pend;
      logic err_lat;
      logic done_lvl;
      logic err_pin;
      logic done_pin;
   } eot_state_t;

   eot_state_t st_q;
   eot_state_t st_d;
   logic tmr_start;
   logic tmr_expire;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Pulse timer
   assign tmr_start = meas_done_in && !st_q.done_hold;

   eot_ms_timer #(
      .CYC_PER_MS(CYC_PER_MS)
   ) u_ms_timer (
      .clk_sys_in(clk_sys_in),
      .nrst_in(nrst_in),
      .start_in(tmr_start),
      .width_in(st_q.done_width),
      .expire_out(tmr_expire),
      .busy_out()
   );

   ////////////////////////////////////////////////////////////////////////////////////////
   // Bus handshakes; one write and one read in flight at a time
   assign s_axi_awready_out = !st_q.aw_got && !st_q.bvalid;
   assign s_axi_wready_out = !st_q.w_got && !st_q.bvalid;
   assign s_axi_arready_out = !st_q.rvalid;
   assign s_axi_bvalid_out = st_q.bvalid;
   assign s_axi_bresp_out = st_q.bresp;
   assign s_axi_rvalid_out = st_q.rvalid;
   assign s_axi_rdata_out = st_q.rdata;
   assign s_axi_rresp_out = st_q.rresp;
   assign measurement_done_output_out = st_q.done_pin;
   assign err_line_out = st_q.err_pin;
   assign irq_out = |(st_q.status & st_q.int_en);

   ////////////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      logic [EV_W-1:0] clr;
      logic [EV_W-1:0] ev;
      logic [7:0] wv;
      logic [AW-1:0] ra;
      clr = '0;
      ev = '0;
      wv = '0;
      ra = '0;
      st_d = st_q;

      // Connector inputs cross in through two flops
      st_d.ext_s1 = ext_pins_in;
      st_d.ext_s2 = st_q.ext_s1;

      // Write channel
      if (st_q.bvalid && s_axi_bready_in)
      begin
         st_d.bvalid = 1'b0;
      end
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
         st_d.aw_got = 1'b1;
         st_d.aw_addr = {s_axi_awaddr_in[AW-1:2], 2'h0};
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
         st_d.w_got = 1'b1;
         st_d.w_data = s_axi_wdata_in;
         st_d.w_strb = s_axi_wstrb_in;
      end
      if (st_d.aw_got && st_d.w_got && !st_q.bvalid)
      begin
         st_d.aw_got = 1'b0;
         st_d.w_got = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = RESP_OKAY;
         wv = st_d.w_data[7:0];
         // Every field lives in byte lane 0
         case (st_d.aw_addr)
            ADDR_CTRL:
            begin
               if (st_d.w_strb[0])
               begin
                  st_d.sync_mode = wv[CTRL_SYNC_BIT];
                  st_d.done_hold = wv[CTRL_HOLD_BIT];
                  st_d.test_mode = wv[CTRL_TEST_BIT];
               end
            end
            ADDR_WIDTH:
            begin
               // Out-of-range widths clamp rather than fault
               if (st_d.w_strb[0])
               begin
                  if (wv < {1'b0, WIDTH_MIN})
                  begin
                     st_d.done_width = WIDTH_MIN;
                  end
                  else if (wv > {1'b0, WIDTH_MAX})
                  begin
                     st_d.done_width = WIDTH_MAX;
                  end
                  else
                  begin
                     st_d.done_width = wv[MS_W-1:0];
                  end
               end
            end
            ADDR_FORCE:
            begin
               if (st_d.w_strb[0])
               begin
                  st_d.force_done = wv[FORCE_DONE_BIT];
                  st_d.force_err = wv[FORCE_ERR_BIT];
               end
            end
            ADDR_CLR:
            begin
               if (st_d.w_strb[0])
               begin
                  clr = wv[EV_W-1:0];
               end
            end
            ADDR_EN:
            begin
               if (st_d.w_strb[0])
               begin
                  st_d.int_en = wv[EV_W-1:0];
               end
            end
            ADDR_IN, ADDR_STAT, ADDR_OUT:
            begin
               // Read-only: write accepted and dropped
            end
            default:
            begin
               st_d.bresp = RESP_SLVERR;
            end
         endcase
      end

      // Read channel
      if (st_q.rvalid && s_axi_rready_in)
      begin
         st_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid_in && s_axi_arready_out)
      begin
         ra = {s_axi_araddr_in[AW-1:2], 2'h0};
         st_d.rvalid = 1'b1;
         st_d.rresp = RESP_OKAY;
         st_d.rdata = '0;
         case (ra)
            ADDR_CTRL:
            begin
               st_d.rdata[CTRL_SYNC_BIT] = st_q.sync_mode;
               st_d.rdata[CTRL_HOLD_BIT] = st_q.done_hold;
               st_d.rdata[CTRL_TEST_BIT] = st_q.test_mode;
            end
            ADDR_WIDTH: st_d.rdata[MS_W-1:0] = st_q.done_width;
            ADDR_FORCE:
            begin
               st_d.rdata[FORCE_DONE_BIT] = st_q.force_done;
               st_d.rdata[FORCE_ERR_BIT] = st_q.force_err;
            end
            ADDR_IN: st_d.rdata[IN_W-1:0] = st_q.ext_s2;
            ADDR_STAT: st_d.rdata[EV_W-1:0] = st_q.status;
            ADDR_CLR: st_d.rdata = '0;
            ADDR_EN: st_d.rdata[EV_W-1:0] = st_q.int_en;
            ADDR_OUT:
            begin
               st_d.rdata[OUT_DONE_BIT] = st_q.done_pin;
               st_d.rdata[OUT_ERR_BIT] = st_q.err_pin;
            end
            default: st_d.rresp = RESP_SLVERR;
         endcase
      end

      ////////////////////////////////////////////////////////////////////////////////////
      // Error capture
      if (meas_start_in)
      begin
         st_d.err_pend = 1'b0;
      end
      // Outside sampling nothing reaches the pending flag
      if (st_q.sync_mode && sampling_in && (contact_err_in || route_err_in))
      begin
         st_d.err_pend = 1'b1;
      end
      if (meas_start_in)
      begin
         st_d.err_lat = 1'b0;
      end
      if (st_q.sync_mode)
      begin
         if (meas_done_in)
         begin
            st_d.err_lat = st_d.err_pend;
         end
      end
      else if (contact_err_in)
      begin
         // New error beats the start-of-cycle clear
         st_d.err_lat = 1'b1;
      end

      // Measurement-done level
      if (meas_start_in)
      begin
         st_d.done_lvl = 1'b0;
      end
      if (tmr_expire && !st_q.done_hold)
      begin
         st_d.done_lvl = 1'b0;
      end
      if (meas_done_in)
      begin
         st_d.done_lvl = 1'b1;
      end

      // Pins follow the next values so error and done leave on the same edge
      st_d.err_pin = st_d.test_mode ? st_d.force_err : st_d.err_lat;
      st_d.done_pin = st_d.test_mode ? st_d.force_done : st_d.done_lvl;

      // Sticky events; a set in the clearing cycle survives
      ev[EV_ERR_BIT] = st_d.err_lat && !st_q.err_lat;
      ev[EV_DONE_BIT] = meas_done_in;
      ev[EV_CC_BIT] = contact_err_in;
      st_d.status = (st_q.status & ~clr) | ev;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         st_q <= '0;
         st_q.sync_mode <= CTRL_SYNC_RST;
         st_q.done_hold <= CTRL_HOLD_RST;
         st_q.test_mode <= CTRL_TEST_RST;
         st_q.done_width <= WIDTH_RST;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking chk_cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!nrst_in);

   mode_default_a: assert property ($past(nrst_in) == 1'b0 |-> !st_q.sync_mode)
      else $error("Error timing not asynchronous after reset");

   sync_sample_a: assert property (
      st_q.sync_mode && sampling_in && route_err_in && !meas_start_in |=> st_q.err_pend)
      else $error("Sampling error missed in synchronous mode");

   sync_ignore_a: assert property (
      st_q.sync_mode && !sampling_in && !st_q.err_pend |=> !st_q.err_pend)
      else $error("Error outside sampling was taken");

   sync_with_done_a: assert property (
      st_q.sync_mode && !st_q.test_mode && meas_done_in && !meas_start_in
      && st_d.test_mode == 1'b0 |=> measurement_done_output_out
      && err_line_out == $past(st_q.err_pend || (sampling_in && (contact_err_in || route_err_in))))
      else $error("Error line not presented with measurement-done");

   async_realtime_a: assert property (
      !st_q.sync_mode && contact_err_in && !sampling_in |=> st_q.err_lat)
      else $error("Contact error outside sampling missed");

   async_indep_a: assert property (
      !st_q.sync_mode && !st_d.test_mode && contact_err_in && !meas_done_in |=> err_line_out)
      else $error("Asynchronous error waited for measurement-done");

   input_view_a: assert property (
      s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in[AW-1:2] == ADDR_IN[AW-1:2]
      |=> s_axi_rvalid_out && s_axi_rdata_out[IN_W-1:0] == $past(st_q.ext_s2))
      else $error("Input state read wrong");

   test_force_a: assert property (
      st_q.test_mode |-> err_line_out == st_q.force_err
      && measurement_done_output_out == st_q.force_done)
      else $error("Outputs not forced in test mode");

   hold_level_a: assert property (
      st_q.done_hold && st_q.done_lvl && !meas_start_in |=> st_q.done_lvl)
      else $error("Held measurement-done dropped early");

   clear_next_a: assert property (
      meas_start_in && !meas_done_in && !contact_err_in |=> !st_q.err_lat)
      else $error("Error not cleared at next cycle start");

   sync_err_c: cover property (st_q.sync_mode && meas_done_in && st_q.err_pend);
   async_err_c: cover property (!st_q.sync_mode && $rose(st_q.err_lat) && !meas_done_in);
   hold_done_c: cover property (st_q.done_hold && $rose(st_q.done_lvl));
   test_out_c: cover property (st_q.test_mode && st_q.force_err);

endmodule

// file: core/eot_ms_timer.sv
// Millisecond pulse timer for the measurement-done output
`timescale 1ns/10ps
module eot_ms_timer
   import eot_pkg::*;
#(
   parameter int unsigned CYC_PER_MS = DONE_UNIT_CYC
)
(
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic start_in,
   input wire logic [MS_W-1:0] width_in,
   output logic expire_out,
   output logic busy_out
);

   localparam int unsigned CW = $clog2(CYC_PER_MS + 1);
   localparam logic [CW-1:0] CYC_LAST = CW'(CYC_PER_MS - 1);

   typedef struct packed
   {
      logic busy;
      logic [CW-1:0] cyc;
      logic [MS_W-1:0] ms;
      logic [MS_W-1:0] width;
   } eot_tmr_t;

   eot_tmr_t tmr_q;
   eot_tmr_t tmr_d;
   logic expire;
   logic [31:0] tot_q;

   // Combinational end so the caller drops its level on the last counted cycle
   assign expire = tmr_q.busy && (tmr_q.cyc == CYC_LAST) && (tmr_q.ms == tmr_q.width - 7'h01);
   assign expire_out = expire;
   assign busy_out = tmr_q.busy;

   always_comb
   begin
      tmr_d = tmr_q;
      if (tmr_q.busy)
      begin
         if (tmr_q.cyc == CYC_LAST)
         begin
            tmr_d.cyc = '0;
            tmr_d.ms = tmr_q.ms + 7'h01;
            if (expire)
            begin
               tmr_d.busy = 1'b0;
            end
         end
         else
         begin
            tmr_d.cyc = tmr_q.cyc + CW'(1);
         end
      end
      // A new start retriggers and latches the width for the whole pulse
      if (start_in)
      begin
         tmr_d.busy = 1'b1;
         tmr_d.cyc = '0;
         tmr_d.ms = '0;
         tmr_d.width = width_in;
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         tmr_q <= '0;
      end
      else
      begin
         tmr_q <= tmr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Checks
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in || start_in)
      begin
         tot_q <= '0;
      end
      else if (tmr_q.busy)
      begin
         tot_q <= tot_q + 32'h1;
      end
   end

   pulse_exact_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      expire_out && !start_in |-> tot_q == (32'(tmr_q.width) * CYC_PER_MS) - 32'h1)
      else $error("Pulse width differs from programmed milliseconds");

   start_busy_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      start_in |=> busy_out && !expire_out)
      else $error("Timer did not start");

   pulse_done_c: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
      expire_out && !start_in);

endmodule

// file: inc/eot_pkg.sv
// Constants shared by the error output timing block
package eot_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned DONE_UNIT_MS = 1;
   localparam int unsigned DONE_UNIT_CYC = (CLK_HZ / 1000) * DONE_UNIT_MS;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int AW = 8;
   localparam int DW = 32;
   localparam int IN_W = 8;
   localparam int MS_W = 7;
   localparam int EV_W = 3;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
   localparam logic [AW-1:0] ADDR_WIDTH = 8'h04;
   localparam logic [AW-1:0] ADDR_FORCE = 8'h08;
   localparam logic [AW-1:0] ADDR_IN = 8'h0c;
   localparam logic [AW-1:0] ADDR_STAT = 8'h10;
   localparam logic [AW-1:0] ADDR_CLR = 8'h14;
   localparam logic [AW-1:0] ADDR_EN = 8'h18;
   localparam logic [AW-1:0] ADDR_OUT = 8'h1c;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CTRL_SYNC_BIT = 0;
   localparam int CTRL_HOLD_BIT = 1;
   localparam int CTRL_TEST_BIT = 2;
   localparam int FORCE_DONE_BIT = 0;
   localparam int FORCE_ERR_BIT = 1;
   localparam int OUT_DONE_BIT = 0;
   localparam int OUT_ERR_BIT = 1;
   localparam int EV_ERR_BIT = 0;
   localparam int EV_DONE_BIT = 1;
   localparam int EV_CC_BIT = 2;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Reset values and limits
   localparam logic CTRL_SYNC_RST = 1'h0;
   localparam logic CTRL_HOLD_RST = 1'h0;
   localparam logic CTRL_TEST_RST = 1'h0;
   localparam logic [MS_W-1:0] WIDTH_RST = 7'h05;
   localparam logic [MS_W-1:0] WIDTH_MIN = 7'h01;
   localparam logic [MS_W-1:0] WIDTH_MAX = 7'h64;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
